/* File: src/asq6_defs.svh */
// register offset, write mask, field positions, reset value and first internal source code for the step-6 config
`ifndef ASQ6_DEFS_SVH
`define ASQ6_DEFS_SVH

`define ASQ6_ADDR_STEP6_CFG   8'h96
`define ASQ6_STEP6_RESET      16'h0006
`define ASQ6_WRITE_MASK       16'hE01F
`define ASQ6_BIT_ENABLE       15
`define ASQ6_GAIN_HI          14
`define ASQ6_GAIN_LO          13
`define ASQ6_BIT_NEG          4
`define ASQ6_POS_HI           3
`define ASQ6_POS_LO           0
`define ASQ6_POS_FIRST_INT    4'h8

`endif

/* File: src/asq6_pkg.sv */
// types for the step-6 sequencer configuration register
package asq6_pkg;

  // gain applied to the converter
  typedef enum logic [1:0] {
    ASQ6_GAIN_X1 = 2'h0,
    ASQ6_GAIN_X2 = 2'h1,
    ASQ6_GAIN_X4 = 2'h2
  } asq6_gain_t;

  // negative input as routed to the converter
  typedef enum logic [1:0] {
    ASQ6_NEG_GROUND = 2'h0,
    ASQ6_NEG_EXT7   = 2'h1,
    ASQ6_NEG_AUTO   = 2'h2
  } asq6_neg_t;

  // settings handed to the converter front end during step 6
  typedef struct packed {
    logic       active;
    asq6_gain_t gain;
    logic       internal;
    logic [3:0] positive;
    asq6_neg_t  negative;
  } asq6_route_t;

  // host register access
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } asq6_access_t;

endpackage

/* File: src/asq6_step6_cfg.sv */
// step-6 configuration register of the auxiliary converter sequencer
`include "asq6_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module asq6_step6_cfg (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // register access from the serial host interface
  input  wire asq6_pkg::asq6_access_t host_acc,
  output var  logic [15:0]           host_rdata,
  output var  logic                  host_rvalid,
  // sequencer handshake
  input  wire logic                  seq_step6_start,
  input  wire logic                  seq_step6_done,
  output var  logic                  seq_step6_skip,
  // routing to the converter front end
  output var  asq6_pkg::asq6_route_t conv_route
);

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic asq6_pkg::asq6_gain_t gain_decode(input logic [1:0] code);
    case (code)
      2'h0:    gain_decode = asq6_pkg::ASQ6_GAIN_X1;
      2'h1:    gain_decode = asq6_pkg::ASQ6_GAIN_X2;
      default: gain_decode = asq6_pkg::ASQ6_GAIN_X4;
    endcase
  endfunction

  function automatic logic is_internal(input logic [3:0] pos);
    is_internal = (pos >= `ASQ6_POS_FIRST_INT);
  endfunction

  // ****************************************************
  // register
  // ****************************************************
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic        hit;

  always_comb begin
    hit        = (host_acc.addr == `ASQ6_ADDR_STEP6_CFG);
    cfg_nxt    = cfg_r;
    rdata_nxt  = 16'h0000;
    rvalid_nxt = host_acc.rd_en;
    if (host_acc.wr_en && hit) begin
      cfg_nxt = host_acc.wdata & `ASQ6_WRITE_MASK;
    end
    // unmapped reads answer zero
    if (host_acc.rd_en && hit) begin
      rdata_nxt = cfg_r & `ASQ6_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r    <= `ASQ6_STEP6_RESET;
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      cfg_r    <= cfg_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign host_rdata  = rdata_r;
  assign host_rvalid = rvalid_r;

  // ****************************************************
  // step control
  // ****************************************************
  typedef enum logic [1:0] {
    ASQ6_IDLE = 2'b00,
    ASQ6_CONV = 2'b01
  } asq6_state_t;

  asq6_state_t           state_r;
  asq6_state_t           state_nxt;
  asq6_pkg::asq6_route_t route_r;
  asq6_pkg::asq6_route_t route_nxt;
  logic                  skip_r;
  logic                  skip_nxt;
  logic [3:0]            pos;

  always_comb begin
    pos       = cfg_r[`ASQ6_POS_HI:`ASQ6_POS_LO];
    state_nxt = state_r;
    route_nxt = route_r;
    skip_nxt  = 1'b0;
    case (state_r)
      ASQ6_IDLE: begin
        if (seq_step6_start) begin
          if (!cfg_r[`ASQ6_BIT_ENABLE]) begin
            skip_nxt = 1'b1;
          end else begin
            state_nxt       = ASQ6_CONV;
            route_nxt.active = 1'b1;
            route_nxt.gain  = gain_decode(cfg_r[`ASQ6_GAIN_HI:`ASQ6_GAIN_LO]);
            route_nxt.positive = pos;
            route_nxt.internal = is_internal(pos);
            if (is_internal(pos)) begin
              route_nxt.negative = asq6_pkg::ASQ6_NEG_AUTO;
            end else if (cfg_r[`ASQ6_BIT_NEG]) begin
              route_nxt.negative = asq6_pkg::ASQ6_NEG_EXT7;
            end else begin
              route_nxt.negative = asq6_pkg::ASQ6_NEG_GROUND;
            end
          end
        end
      end
      ASQ6_CONV: begin
        // settings held for the whole conversion, even if rewritten meanwhile
        if (seq_step6_done) begin
          state_nxt        = ASQ6_IDLE;
          route_nxt.active = 1'b0;
        end
      end
      default: begin
        state_nxt = ASQ6_IDLE;
        route_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ASQ6_IDLE;
      route_r <= '0;
      skip_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      route_r <= route_nxt;
      skip_r  <= skip_nxt;
    end
  end

  assign conv_route     = route_r;
  assign seq_step6_skip = skip_r;

  // ****************************************************
  // checks
  // ****************************************************
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (reset)
    host_rvalid |-> host_rdata[12:5] == 8'h00)
    else $error("reserved bits read nonzero");

  AST_READBACK: assert property (@(posedge clk) disable iff (reset)
    host_acc.wr_en && hit && !host_acc.rd_en ##1 host_acc.rd_en && hit && !host_acc.wr_en
    |=> host_rdata == ($past(host_acc.wdata, 2) & 16'hE01F))
    else $error("readback differs from write");

  AST_SKIP: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && !cfg_r[15] |=> seq_step6_skip && !conv_route.active)
    else $error("disabled step not skipped");

  AST_RUN: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && cfg_r[15] |=> conv_route.active && !seq_step6_skip)
    else $error("enabled step not started");

  AST_GAIN: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && cfg_r[15] && cfg_r[14:13] == 2'h3
    |=> conv_route.gain == asq6_pkg::ASQ6_GAIN_X4)
    else $error("gain code 3 not gain four");

  AST_AUTO_NEG: assert property (@(posedge clk) disable iff (reset)
    conv_route.active && conv_route.positive[3] |-> conv_route.negative == asq6_pkg::ASQ6_NEG_AUTO)
    else $error("internal source without automatic negative");

  AST_EXT_NEG: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && cfg_r[15] && !cfg_r[3] && cfg_r[4]
    |=> conv_route.negative == asq6_pkg::ASQ6_NEG_EXT7)
    else $error("negative select ignored");

  AST_INTERNAL: assert property (@(posedge clk) disable iff (reset)
    conv_route.active |-> conv_route.internal == conv_route.positive[3])
    else $error("internal flag wrong");

  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    conv_route.active && !seq_step6_done |=> $stable(conv_route.positive))
    else $error("positive select changed mid conversion");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (reset)
    host_acc.rd_en && !hit |=> host_rvalid && host_rdata == 16'h0000)
    else $error("unmapped read not zero");

  AST_RSVD_STORE: assert property (@(posedge clk) disable iff (reset)
    cfg_r[12:5] == 8'h00)
    else $error("reserved bits stored");

  AST_GAIN_X2: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && cfg_r[15] && cfg_r[14:13] == 2'h1
    |=> conv_route.gain == asq6_pkg::ASQ6_GAIN_X2)
    else $error("gain code 1 not gain two");

  AST_GND_NEG: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && cfg_r[15] && !cfg_r[3] && !cfg_r[4]
    |=> conv_route.negative == asq6_pkg::ASQ6_NEG_GROUND)
    else $error("ground negative not chosen");

  AST_POS_LATCH: assert property (@(posedge clk) disable iff (reset)
    state_r == ASQ6_IDLE && seq_step6_start && cfg_r[15]
    |=> conv_route.positive == $past(cfg_r[3:0]) && conv_route.internal == $past(cfg_r[3]))
    else $error("positive select not latched");

  AST_END: assert property (@(posedge clk) disable iff (reset)
    conv_route.active && seq_step6_done |=> !conv_route.active)
    else $error("step not ended on done");

endmodule

`default_nettype wire

/* File: test/asq6_step6_cfg_test.sv */
// self-checking bench for the step-6 sequencer configuration register
`include "asq6_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module asq6_step6_cfg_test;
  // ************
  // signals
  // ************
  logic                   clk;
  logic                   reset;
  asq6_pkg::asq6_access_t host_acc;
  logic [15:0]            host_rdata;
  logic                   host_rvalid;
  logic                   seq_step6_start;
  logic                   seq_step6_done;
  logic                   seq_step6_skip;
  asq6_pkg::asq6_route_t  conv_route;
  asq6_pkg::asq6_route_t  exp;
  logic [3:0]             c;
  logic [15:0]            d;
  int                     n_errors;
  int                     n_tests;
  int                     cycles;

  asq6_step6_cfg asq6_step6_cfg_i (
    .clk             (clk),
    .reset           (reset),
    .host_acc        (host_acc),
    .host_rdata      (host_rdata),
    .host_rvalid     (host_rvalid),
    .seq_step6_start (seq_step6_start),
    .seq_step6_done  (seq_step6_done),
    .seq_step6_skip  (seq_step6_skip),
    .conv_route      (conv_route)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ************
  // compare, access and step tasks
  // ************
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic cmp_route(input asq6_pkg::asq6_route_t got, input asq6_pkg::asq6_route_t want);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  // strobe left high: every write is followed by a read, whose first assignment lowers it
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    host_acc = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
    @(negedge clk);
  endtask

  // read data stands one cycle, so it is looked at on the next falling edge
  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    host_acc = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    host_acc.rd_en = 1'b0;
    cmp_word({15'h0000, host_rvalid}, 16'h0001);
    cmp_word(host_rdata, want);
    @(negedge clk);
  endtask

  task automatic step(input asq6_pkg::asq6_route_t want, input logic [15:0] skip);
    seq_step6_start = 1'b1;
    @(negedge clk);
    seq_step6_start = 1'b0;
    cmp_word({15'h0000, seq_step6_skip}, skip);
    cmp_route(conv_route, want);
    seq_step6_done = 1'b1;
    @(negedge clk);
    seq_step6_done = 1'b0;
    cmp_word({14'h0000, seq_step6_skip, conv_route.active}, 16'h0000);
  endtask

  task automatic conclude;
    $display("mismatches=%0d comparisons=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ************
  // hang guard and main sequence
  // ************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    reset = 1'b1;
    host_acc = '0;
    seq_step6_start = 1'b0;
    seq_step6_done = 1'b0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rd(`ASQ6_ADDR_STEP6_CFG, 16'h0006);
    rd(8'h95, 16'h0000);
    exp = '0;
    step(exp, 16'h0001);
    wr(8'h97, 16'hFFFF);
    rd(`ASQ6_ADDR_STEP6_CFG, 16'h0006);
    wr(`ASQ6_ADDR_STEP6_CFG, 16'hFFFF);
    rd(`ASQ6_ADDR_STEP6_CFG, 16'hE01F);
    // every positive code, every gain code, both negative settings
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      d = {1'b1, c[1:0], 8'h00, c[2], c};
      exp.active = 1'b1;
      exp.gain = (c[1:0] == 2'h0) ? asq6_pkg::ASQ6_GAIN_X1 :
                 (c[1:0] == 2'h1) ? asq6_pkg::ASQ6_GAIN_X2 : asq6_pkg::ASQ6_GAIN_X4;
      exp.internal = c[3];
      exp.positive = c;
      exp.negative = c[3] ? asq6_pkg::ASQ6_NEG_AUTO :
                     (c[2] ? asq6_pkg::ASQ6_NEG_EXT7 : asq6_pkg::ASQ6_NEG_GROUND);
      wr(`ASQ6_ADDR_STEP6_CFG, d);
      rd(`ASQ6_ADDR_STEP6_CFG, d);
      step(exp, 16'h0000);
    end
    // clearing the enable skips the step; the route's other fields keep their last values
    wr(`ASQ6_ADDR_STEP6_CFG, 16'h0005);
    rd(`ASQ6_ADDR_STEP6_CFG, 16'h0005);
    exp.active = 1'b0;
    step(exp, 16'h0001);
    // mid-run reset brings back the documented value and a quiet route
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    cmp_route(conv_route, '0);
    cmp_word({14'h0000, host_rvalid, seq_step6_skip}, 16'h0000);
    rd(`ASQ6_ADDR_STEP6_CFG, 16'h0006);
    conclude();
  end
endmodule
`default_nettype wire
